// ---- common/csc_defs.svh ----
// Functional notes
// - reading group status 1 puts own interrupt flag on the selected bus bit.
// - reading group status 2 puts own sync-loss flag on the selected bus bit.
// - reading group status 3 puts user-selected status one on the selected bit.
// - reading group status 4 puts user-selected status two on the selected bit.
// - group reads drive only the one selected bit; other bits float.
// - group reads answered only while group enable bit is set.
// - bus-line select value n drives bus bit n; host keeps values unique.
// - backplane clock is derived from the recovered line clock reference.
// - backplane enable 0 holds pin low, 1 drives synthesized clock.
// - rate field picks 16.384, 8.192, 4.096 or 2.048 MHz.
// - gapped clock pulses only in channels marked as selected.
// - gapped clock never pulses during the framing bit.
// - receive and transmit gapped enables act independently.
// - format bit per path: 0 all eight bits, 1 seven bits.
// - seven-bit format drops the clock for the channel LSB.
// - user outputs clear on power-up, hardware and software reset.
// - each stored user output bit drives its pin level directly.
// - receive level threshold field codes 2.5 dB steps.
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

`define CSC_OFF_BP_CTL     8'h71
`define CSC_OFF_GAP_CTL    8'h72
`define CSC_OFF_UOUT_CTL   8'h73
`define CSC_OFF_GRP_CTL1   8'hB0
`define CSC_OFF_GRP_CTL2   8'hB1
`define CSC_OFF_GRP_INT    8'hB2
`define CSC_OFF_GRP_SYNC   8'hB3
`define CSC_OFF_GRP_UST1   8'hB4
`define CSC_OFF_GRP_UST2   8'hB5

`define CSC_RST_CTL        8'h00

`define CSC_BP_EN_BIT      0
`define CSC_BP_RATE_LSB    1
`define CSC_GAP_RX_EN_BIT  0
`define CSC_GAP_RX_FMT_BIT 1
`define CSC_GAP_TX_EN_BIT  2
`define CSC_GAP_TX_FMT_BIT 3
`define CSC_UOUT_LSB       0
`define CSC_RLT_LSB        4
`define CSC_GRP_EN_BIT     0
`define CSC_GRP_SEL_LSB    1
`define CSC_UST1_SEL_LSB   0
`define CSC_UST2_SEL_LSB   4

// channel bit position that carries no data in seven-bit format
`define CSC_LSB_POS        3'h7
`define CSC_NUM_ITEMS      6

`endif

// ---- common/csc_pkg.sv ----
package csc_pkg;

  // line timing seen by one channel-clock path
  typedef struct packed {
    logic       bit_clk;     // line bit clock level
    logic       frame_bit;   // framing bit position
    logic       chan_sel;    // current channel marked for gapping
    logic [2:0] bit_idx;     // bit within channel, 0 is msb
    logic       normal_clk;  // pin level in its normal function
  } csc_path_t;

  // per-path controls
  typedef struct packed {
    logic gap_en;
    logic fmt56;
  } csc_gap_ctl_t;

  typedef enum logic [1:0] {
    CSC_BP_16M384,
    CSC_BP_8M192,
    CSC_BP_4M096,
    CSC_BP_2M048
  } csc_bp_rate_t;

endpackage

// ---- sim/common_status_clock_control_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csc_defs.svh"

module common_status_clock_control_tb import csc_pkg::*;;
  typedef struct packed {
    logic [7:0] ctl1, ctl2;
    logic       irq, sync;
    logic [5:0] items;
    logic [7:0] addr, oe, data;
  } csc_row_t;

  logic clk, rst, soft_rst, wr, rd, irq, sync, bp, rxc, txc;
  logic synth = 1'b0;
  logic [7:0] addr, wdata, rdata, oe, d, e;
  logic [5:0] items;
  logic [3:0] uout, rlt;
  csc_path_t rxp, txp;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int ph = 0;
  int n;
  logic any;

  csc_row_t rows [14] = '{
    '{8'h01, 8'h00, 1'b1, 1'b0, 6'h00, 8'hB2, 8'h01, 8'h01},
    '{8'h0F, 8'h00, 1'b1, 1'b0, 6'h00, 8'hB2, 8'h80, 8'h80},
    '{8'h0B, 8'h00, 1'b0, 1'b1, 6'h3F, 8'hB2, 8'h20, 8'h00},
    '{8'h05, 8'h00, 1'b0, 1'b1, 6'h00, 8'hB3, 8'h04, 8'h04},
    '{8'h07, 8'h00, 1'b1, 1'b0, 6'h3F, 8'hB3, 8'h08, 8'h00},
    '{8'h09, 8'h00, 1'b0, 1'b0, 6'h01, 8'hB4, 8'h10, 8'h10},
    '{8'h03, 8'h05, 1'b0, 1'b0, 6'h20, 8'hB4, 8'h02, 8'h02},
    '{8'h0D, 8'h06, 1'b1, 1'b1, 6'h3F, 8'hB4, 8'h40, 8'h00},
    '{8'h03, 8'h30, 1'b0, 1'b0, 6'h08, 8'hB5, 8'h02, 8'h02},
    '{8'h03, 8'h40, 1'b0, 1'b0, 6'h10, 8'hB5, 8'h02, 8'h02},
    '{8'h01, 8'h12, 1'b0, 1'b0, 6'h02, 8'hB5, 8'h01, 8'h01},
    '{8'h01, 8'h12, 1'b0, 1'b0, 6'h02, 8'hB4, 8'h01, 8'h00},
    '{8'h0E, 8'h00, 1'b1, 1'b1, 6'h3F, 8'hB2, 8'h00, 8'h00},
    '{8'h0E, 8'h00, 1'b1, 1'b1, 6'h3F, 8'hB3, 8'h00, 8'h00}
  };

  csc_top uut (
    .ref_clk_i                    (clk),
    .reset_i                      (rst),
    .soft_reset_i                 (soft_rst),
    .addr_i                       (addr),
    .wdata_i                      (wdata),
    .wr_i                         (wr),
    .rd_i                         (rd),
    .rdata_o                      (rdata),
    .data_oe_o                    (oe),
    .member_interrupt_flag_i      (irq),
    .member_sync_loss_flag_i      (sync),
    .status_items_i               (items),
    .synth_pulse_i                (synth),
    .backplane_clock_pin_o        (bp),
    .rx_path_i                    (rxp),
    .tx_path_i                    (txp),
    .receive_channel_clock_pin_o  (rxc),
    .transmit_channel_clock_pin_o (txc),
    .user_output_o                (uout),
    .receive_level_threshold_o    (rlt)
  );

  csc_host_model host (
    .ref_clk_i (clk),
    .rdata_i   (rdata),
    .data_oe_i (oe),
    .addr_o    (addr),
    .wdata_o   (wdata),
    .wr_o      (wr),
    .rd_o      (rd)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pll stand-in: one tick every third cycle
  always @(negedge clk) begin
    ph    <= (ph == 2) ? 0 : ph + 1;
    synth <= (ph == 2);
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      $display("timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  function automatic csc_path_t mkp(input int bc, fb, cs, idx, nc);
    return '{1'(bc), 1'(fb), 1'(cs), 3'(idx), 1'(nc)};
  endfunction

  task automatic gap(input logic [7:0] c, input csc_path_t r, t, input logic er, et);
    host.write(`CSC_OFF_GAP_CTL, c);
    rxp = r;
    txp = t;
    repeat (3) @(negedge clk);
    chk1("receive chan clock", er, rxc);
    chk1("transmit chan clock", et, txc);
  endtask

  // ticks between the second and third pin change, skipping the rate switch
  task automatic bp_period(output int ticks);
    int chg;
    logic last;
    chg = 0;
    ticks = 0;
    last = bp;
    for (int k = 0; k < 400 && chg < 3; k++) begin
      @(negedge clk);
      if (bp !== last) begin
        chg++;
        if (chg < 3) ticks = 0;
      end
      if (synth) ticks++;
      last = bp;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    soft_rst = 1'b0;
    irq = 1'b0;
    sync = 1'b0;
    items = 6'h00;
    rxp = '0;
    txp = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk8("user outputs at reset", 8'h00, {4'h0, uout});
    for (int i = 8'h71; i <= 8'h73; i++) begin
      host.read(8'(i), d, e);
      chk8("control reset value", 8'h00, d);
      host.write(8'(i), 8'hFF);
      host.read(8'(i), d, e);
      chk8("control readback", (i == 8'h71) ? 8'h07 : (i == 8'h72) ? 8'h0F : 8'hFF, d);
    end
    host.read(8'h40, d, e);
    chk8("unmapped enables", 8'hFF, e);
    $display("test registers done");
    foreach (rows[i]) begin
      host.write(`CSC_OFF_GRP_CTL1, rows[i].ctl1);
      host.write(`CSC_OFF_GRP_CTL2, rows[i].ctl2);
      irq = rows[i].irq;
      sync = rows[i].sync;
      items = rows[i].items;
      host.read(rows[i].addr, d, e);
      chk8("group drive enable", rows[i].oe, e);
      chk8("group data", rows[i].data, d & e);
    end
    irq = 1'b0;
    host.write(`CSC_OFF_GRP_CTL1, 8'h01);
    host.write(`CSC_OFF_GRP_INT, 8'hFF);
    host.read(`CSC_OFF_GRP_INT, d, e);
    chk8("group data after write", 8'h00, d & e);
    chk8("group enables after write", 8'h01, e);
    irq = 1'b1;
    host.read(`CSC_OFF_GRP_INT, d, e);
    chk8("group data live", 8'h01, d & e);
    $display("test group status done");
    for (int i = 0; i < 16; i++) begin
      host.write(`CSC_OFF_UOUT_CTL, {i[3:0], ~i[3:0]});
      @(negedge clk);
      chk8("user outputs", {4'h0, ~i[3:0]}, {4'h0, uout});
      chk8("level threshold", 8'(i), {4'h0, rlt});
    end
    host.write(`CSC_OFF_UOUT_CTL, 8'h0F);
    @(negedge clk);
    chk8("user outputs before soft reset", 8'h0F, {4'h0, uout});
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    @(negedge clk);
    chk8("user outputs after soft reset", 8'h00, {4'h0, uout});
    host.write(`CSC_OFF_UOUT_CTL, 8'h0F);
    @(negedge clk);
    chk8("user outputs before reset", 8'h0F, {4'h0, uout});
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk8("user outputs after reset", 8'h00, {4'h0, uout});
    $display("test user outputs done");
    for (int r = 0; r < 4; r++) begin
      host.write(`CSC_OFF_BP_CTL, {5'h00, 2'(r), 1'b1});
      bp_period(n);
      chk8("backplane half period ticks", 8'(1 << r), 8'(n));
    end
    host.write(`CSC_OFF_BP_CTL, 8'h06);
    repeat (2) @(negedge clk);
    any = 1'b0;
    repeat (40) begin
      @(negedge clk);
      any = any | bp;
    end
    chk1("backplane disabled", 1'b0, any);
    $display("test backplane done");
    gap(8'h00, mkp(1, 0, 1, 3, 0), mkp(0, 0, 0, 0, 1), 1'b0, 1'b1);
    gap(8'h01, mkp(1, 0, 1, 3, 0), mkp(1, 0, 1, 3, 0), 1'b1, 1'b0);
    gap(8'h05, mkp(1, 0, 0, 3, 1), mkp(1, 1, 1, 0, 1), 1'b0, 1'b0);
    gap(8'h0F, mkp(1, 0, 1, 7, 1), mkp(1, 0, 1, 6, 0), 1'b0, 1'b1);
    gap(8'h05, mkp(1, 0, 1, 7, 0), mkp(0, 0, 1, 2, 1), 1'b1, 1'b0);
    gap(8'h04, mkp(0, 0, 1, 3, 1), mkp(1, 0, 1, 7, 0), 1'b1, 1'b1);
    $display("test gapped clocks done");
    tally_and_finish();
  end
endmodule

`default_nettype wire

// ---- sim/csc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module csc_host_model (
  input  wire logic       ref_clk_i,  // system clock
  input  wire logic [7:0] rdata_i,    // read data from device
  input  wire logic [7:0] data_oe_i,  // device drive enables
  output logic      [7:0] addr_o,     // register address
  output logic      [7:0] wdata_o,    // write data
  output logic            wr_o,       // write strobe
  output logic            rd_o        // read strobe
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // unused control bits always go out as zero
  function automatic logic [7:0] used_bits(input logic [7:0] a);
    case (a)
      8'h71:   return 8'h07;
      8'h72:   return 8'h0F;
      8'hB0:   return 8'h0F;
      8'hB1:   return 8'h77;
      default: return 8'hFF;
    endcase
  endfunction

  // one strobe cycle per access; lines change only at the falling edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o  = a;
    wdata_o = d & used_bits(a);
    wr_o    = 1'b1;
    @(negedge ref_clk_i);
    wr_o    = 1'b0;
    // idle lines must not look like a held request
    addr_o  = ~addr_o;
    wdata_o = ~wdata_o;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic [7:0] oe);
    @(negedge ref_clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge ref_clk_i);
    d      = rdata_i;
    oe     = data_oe_i;
    rd_o   = 1'b0;
    addr_o = ~addr_o;
  endtask
endmodule

`default_nettype wire

// ---- verilog/csc_gap_clock.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csc_defs.svh"

module csc_gap_clock
  import csc_pkg::*;
(
  input  wire logic         ref_clk_i,  // system clock
  input  wire logic         reset_i,    // sync reset, active high
  input  wire csc_path_t    path_i,     // line timing for this path
  input  wire csc_gap_ctl_t ctl_i,      // gapped enable and format
  output logic              pin_o       // channel-clock pin level
);

  logic gate_open;
  logic gapped;
  logic next_pin;

  // framing bit and the dropped lsb both keep the gate shut
  assign gate_open = path_i.chan_sel & ~path_i.frame_bit
                   & ~(ctl_i.fmt56 & (path_i.bit_idx == `CSC_LSB_POS));
  assign gapped    = path_i.bit_clk & gate_open;
  assign next_pin  = ctl_i.gap_en ? gapped : path_i.normal_clk;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_o <= 1'b0;
    end else begin
      pin_o <= next_pin;
    end
  end

  AST_GAP_NO_FBIT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ctl_i.gap_en && path_i.frame_bit) |=> !pin_o)
    else $error("gapped clock pulsed in framing bit");

  AST_GAP_NO_LSB: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ctl_i.gap_en && ctl_i.fmt56 && path_i.bit_idx == `CSC_LSB_POS) |=> !pin_o)
    else $error("seven-bit format clocked the lsb");

  AST_GAP_UNSEL: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ctl_i.gap_en && !path_i.chan_sel) |=> !pin_o)
    else $error("gapped clock pulsed in unselected channel");

endmodule

`default_nettype wire

// ---- verilog/csc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csc_defs.svh"

module csc_top
  import csc_pkg::*;
#(
  parameter int unsigned DATA_W = 8  // host data bus width
)(
  input  wire logic              ref_clk_i,          // 100 MHz system clock
  input  wire logic              reset_i,            // hardware reset, sync, high
  input  wire logic              soft_reset_i,       // software reset pulse
  input  wire logic [7:0]        addr_i,             // host register address
  input  wire logic [DATA_W-1:0] wdata_i,            // host write data
  input  wire logic              wr_i,               // host write strobe
  input  wire logic              rd_i,               // host read strobe
  output logic      [DATA_W-1:0] rdata_o,            // read data
  output logic      [DATA_W-1:0] data_oe_o,          // per-bit drive enable
  input  wire logic              member_interrupt_flag_i, // own interrupt pending
  input  wire logic              member_sync_loss_flag_i, // own receive sync loss
  input  wire logic [`CSC_NUM_ITEMS-1:0] status_items_i,  // selectable alarms
  input  wire logic              synth_pulse_i,      // pll tick, 32.768 MHz rate
  output logic                   backplane_clock_pin_o,   // backplane clock
  input  wire csc_path_t         rx_path_i,          // receive channel timing
  input  wire csc_path_t         tx_path_i,          // transmit channel timing
  output logic                   receive_channel_clock_pin_o,  // receive chan clock
  output logic                   transmit_channel_clock_pin_o, // transmit chan clock
  output logic [3:0]             user_output_o,      // user output pins
  output logic [3:0]             receive_level_threshold_o // threshold code
);

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  logic [7:0] backplane_clock_control;
  logic [7:0] gapped_clock_control;
  logic [7:0] user_output_level_control;
  logic [7:0] group_control_one;
  logic [7:0] group_control_two;

  logic any_reset;
  assign any_reset = reset_i | soft_reset_i;

  logic wr_bp;
  logic wr_gap;
  logic wr_uout;
  logic wr_grp1;
  logic wr_grp2;
  assign wr_bp   = wr_i & (addr_i == `CSC_OFF_BP_CTL);
  assign wr_gap  = wr_i & (addr_i == `CSC_OFF_GAP_CTL);
  assign wr_uout = wr_i & (addr_i == `CSC_OFF_UOUT_CTL);
  assign wr_grp1 = wr_i & (addr_i == `CSC_OFF_GRP_CTL1);
  assign wr_grp2 = wr_i & (addr_i == `CSC_OFF_GRP_CTL2);

  // unused bits are stored as written; the host keeps them zero
  always_ff @(posedge ref_clk_i) begin
    if (any_reset) begin
      backplane_clock_control   <= `CSC_RST_CTL;
      gapped_clock_control      <= `CSC_RST_CTL;
      user_output_level_control <= `CSC_RST_CTL;
      group_control_one         <= `CSC_RST_CTL;
      group_control_two         <= `CSC_RST_CTL;
    end else begin
      if (wr_bp)   backplane_clock_control   <= wdata_i[7:0];
      if (wr_gap)  gapped_clock_control      <= wdata_i[7:0];
      if (wr_uout) user_output_level_control <= wdata_i[7:0];
      if (wr_grp1) group_control_one         <= wdata_i[7:0];
      if (wr_grp2) group_control_two         <= wdata_i[7:0];
    end
  end

  // ------------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------------
  logic         group_enable;
  logic [2:0]   bus_line_select;
  logic [2:0]   user_status_one_select;
  logic [2:0]   user_status_two_select;
  logic         backplane_clock_enable;
  csc_bp_rate_t backplane_rate;

  assign group_enable           = group_control_one[`CSC_GRP_EN_BIT];
  assign bus_line_select        = group_control_one[`CSC_GRP_SEL_LSB +: 3];
  assign user_status_one_select = group_control_two[`CSC_UST1_SEL_LSB +: 3];
  assign user_status_two_select = group_control_two[`CSC_UST2_SEL_LSB +: 3];
  assign backplane_clock_enable = backplane_clock_control[`CSC_BP_EN_BIT];
  assign backplane_rate = csc_bp_rate_t'(backplane_clock_control[`CSC_BP_RATE_LSB +: 2]);

  // pick one status item; codes past the item list report zero
  function automatic logic pick_item(input logic [2:0] sel,
                                     input logic [`CSC_NUM_ITEMS-1:0] items);
    logic r;
    r = 1'b0;
    if (sel < 3'(`CSC_NUM_ITEMS)) begin
      r = items[sel];
    end
    return r;
  endfunction

  // bus-line select n maps to data bit n
  function automatic logic [7:0] line_mask(input logic [2:0] sel);
    return 8'h01 << sel;
  endfunction

  logic member_user_status_one;
  logic member_user_status_two;
  assign member_user_status_one = pick_item(user_status_one_select, status_items_i);
  assign member_user_status_two = pick_item(user_status_two_select, status_items_i);

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic is_grp_int;
  logic is_grp_sync;
  logic is_grp_ust1;
  logic is_grp_ust2;
  logic is_grp_read;
  logic is_ctl_read;
  assign is_grp_int  = addr_i == `CSC_OFF_GRP_INT;
  assign is_grp_sync = addr_i == `CSC_OFF_GRP_SYNC;
  assign is_grp_ust1 = addr_i == `CSC_OFF_GRP_UST1;
  assign is_grp_ust2 = addr_i == `CSC_OFF_GRP_UST2;
  assign is_grp_read = is_grp_int | is_grp_sync | is_grp_ust1 | is_grp_ust2;
  assign is_ctl_read = (addr_i == `CSC_OFF_BP_CTL)   | (addr_i == `CSC_OFF_GAP_CTL)
                     | (addr_i == `CSC_OFF_UOUT_CTL) | (addr_i == `CSC_OFF_GRP_CTL1)
                     | (addr_i == `CSC_OFF_GRP_CTL2);

  // status is sampled live in the read cycle; nothing is latched earlier
  logic member_bit;
  assign member_bit = is_grp_int  ? member_interrupt_flag_i :
                      is_grp_sync ? member_sync_loss_flag_i :
                      is_grp_ust1 ? member_user_status_one  :
                                    member_user_status_two;

  logic [7:0] ctl_word;
  assign ctl_word = (addr_i == `CSC_OFF_BP_CTL)   ? backplane_clock_control   :
                    (addr_i == `CSC_OFF_GAP_CTL)  ? gapped_clock_control      :
                    (addr_i == `CSC_OFF_UOUT_CTL) ? user_output_level_control :
                    (addr_i == `CSC_OFF_GRP_CTL1) ? group_control_one         :
                    (addr_i == `CSC_OFF_GRP_CTL2) ? group_control_two         : 8'h00;

  logic [7:0] sel_mask;
  assign sel_mask = line_mask(bus_line_select);

  // a disabled member stays off the bus so another group member can answer
  logic [7:0] next_oe;
  logic [7:0] next_rdata;
  assign next_oe = !rd_i        ? 8'h00 :
                   is_grp_read  ? (group_enable ? sel_mask : 8'h00) :
                                  8'hFF;
  assign next_rdata = !rd_i       ? 8'h00 :
                      is_grp_read ? (sel_mask & {8{member_bit}}) :
                      is_ctl_read ? ctl_word : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o   <= '0;
      data_oe_o <= '0;
    end else begin
      rdata_o   <= DATA_W'(next_rdata);
      data_oe_o <= DATA_W'(next_oe);
    end
  end

  // ------------------------------------------------------------------
  // backplane clock: the pll tick is locked to the recovered line clock,
  // so dividing it keeps the output locked as well
  // ------------------------------------------------------------------
  logic [2:0] bp_count;
  logic [2:0] bp_mask;
  logic       bp_toggle;
  logic       bp_level;

  assign bp_mask = (backplane_rate == CSC_BP_16M384) ? 3'h0 :
                   (backplane_rate == CSC_BP_8M192)  ? 3'h1 :
                   (backplane_rate == CSC_BP_4M096)  ? 3'h3 : 3'h7;
  assign bp_toggle = synth_pulse_i & ((bp_count & bp_mask) == bp_mask);

  always_ff @(posedge ref_clk_i) begin
    if (any_reset || !backplane_clock_enable) begin
      bp_count <= 3'h0;
      bp_level <= 1'b0;
    end else begin
      if (synth_pulse_i) bp_count <= bp_count + 3'h1;
      if (bp_toggle)     bp_level <= ~bp_level;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (any_reset) begin
      backplane_clock_pin_o <= 1'b0;
    end else begin
      backplane_clock_pin_o <= backplane_clock_enable & bp_level;
    end
  end

  // ------------------------------------------------------------------
  // gapped channel clocks, one per path
  // ------------------------------------------------------------------
  csc_path_t    path_in [2];
  csc_gap_ctl_t path_ctl [2];
  logic         path_pin [2];

  assign path_in[0]         = rx_path_i;
  assign path_in[1]         = tx_path_i;
  assign path_ctl[0].gap_en = gapped_clock_control[`CSC_GAP_RX_EN_BIT];
  assign path_ctl[0].fmt56  = gapped_clock_control[`CSC_GAP_RX_FMT_BIT];
  assign path_ctl[1].gap_en = gapped_clock_control[`CSC_GAP_TX_EN_BIT];
  assign path_ctl[1].fmt56  = gapped_clock_control[`CSC_GAP_TX_FMT_BIT];

  for (genvar p = 0; p < 2; p++) begin : g_path
    csc_gap_clock u_gap (
      .ref_clk_i (ref_clk_i),
      .reset_i   (any_reset),
      .path_i    (path_in[p]),
      .ctl_i     (path_ctl[p]),
      .pin_o     (path_pin[p])
    );
  end

  always_ff @(posedge ref_clk_i) begin
    if (any_reset) begin
      receive_channel_clock_pin_o  <= 1'b0;
      transmit_channel_clock_pin_o <= 1'b0;
    end else begin
      receive_channel_clock_pin_o  <= path_pin[0];
      transmit_channel_clock_pin_o <= path_pin[1];
    end
  end

  // ------------------------------------------------------------------
  // user outputs and threshold
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (any_reset) begin
      user_output_o             <= 4'h0;
      receive_level_threshold_o <= 4'h0;
    end else begin
      user_output_o             <= user_output_level_control[`CSC_UOUT_LSB +: 4];
      receive_level_threshold_o <= user_output_level_control[`CSC_RLT_LSB +: 4];
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_grp_read(logic [7:0] off);
    rd_i && addr_i == off && group_enable;
  endsequence

  sequence s_one_bit_driven;
    data_oe_o == line_mask($past(bus_line_select));
  endsequence

  AST_GRP_INT: assert property (s_grp_read(`CSC_OFF_GRP_INT) |=> s_one_bit_driven
    and rdata_o == (data_oe_o & {8{$past(member_interrupt_flag_i)}}))
    else $error("interrupt status not on selected bit");

  AST_GRP_SYNC: assert property (s_grp_read(`CSC_OFF_GRP_SYNC) |=> s_one_bit_driven
    and rdata_o == (data_oe_o & {8{$past(member_sync_loss_flag_i)}}))
    else $error("sync loss status not on selected bit");

  AST_GRP_UST1: assert property (s_grp_read(`CSC_OFF_GRP_UST1) |=>
    rdata_o == (data_oe_o & {8{$past(member_user_status_one)}}))
    else $error("user status one wrong");

  AST_GRP_UST2: assert property (s_grp_read(`CSC_OFF_GRP_UST2) |=>
    rdata_o == (data_oe_o & {8{$past(member_user_status_two)}}))
    else $error("user status two wrong");

  AST_ONE_LINE: assert property ((rd_i && is_grp_read) |=> $countones(data_oe_o) <= 1)
    else $error("more than one bus bit driven in group read");

  AST_GRP_DISABLED: assert property ((rd_i && is_grp_read && !group_enable)
    |=> data_oe_o == 8'h00)
    else $error("disabled member drove the bus");

  AST_BP_HELD_LOW: assert property ((!backplane_clock_enable && !soft_reset_i)
    [*2] |-> !backplane_clock_pin_o)
    else $error("backplane pin not held low");

  AST_BP_FAST: assert property ((backplane_clock_enable && backplane_rate == CSC_BP_16M384
    && synth_pulse_i && !soft_reset_i && !wr_bp) |=> bp_level != $past(bp_level))
    else $error("fastest rate did not toggle on each tick");

  AST_UOUT: assert property ((wr_uout && !soft_reset_i) ##1 !soft_reset_i
    |=> user_output_o == $past(wdata_i[3:0], 2))
    else $error("user output does not follow written bits");

  AST_UOUT_RST: assert property (soft_reset_i |=> ##1 user_output_o == 4'h0)
    else $error("user outputs not cleared by software reset");

  AST_GRP_RO: assert property ((wr_i && is_grp_read) |=>
    $stable(group_control_one) && $stable(backplane_clock_control))
    else $error("write to group status changed state");

  AST_GRP_RO_ALL: assert property ((wr_i && is_grp_read && !soft_reset_i) |=>
    $stable(gapped_clock_control) && $stable(user_output_level_control)
    && $stable(group_control_two))
    else $error("write to group status changed a control register");

  // outside reads the data lines must be released
  AST_RD_IDLE: assert property (!rd_i |=> data_oe_o == 8'h00 && rdata_o == 8'h00)
    else $error("bus driven outside a read");

  // spare select codes have no status item behind them
  AST_UST_SPARE: assert property ((rd_i && is_grp_ust1 && group_enable
    && user_status_one_select > 3'h5) |=> rdata_o == 8'h00)
    else $error("spare status select did not report zero");

  // pin lags the divider by one flop
  AST_BP_PIN: assert property ((backplane_clock_enable && !soft_reset_i)
    |=> backplane_clock_pin_o == $past(bp_level))
    else $error("backplane pin does not follow divider");

  // slowest rate: the level may only flip on the eighth tick
  AST_BP_SLOW: assert property ((backplane_clock_enable && !soft_reset_i
    && backplane_rate == CSC_BP_2M048 && !(synth_pulse_i && bp_count == 3'h7))
    |=> $stable(bp_level))
    else $error("slowest rate toggled early");

  // one extra flop per path keeps every top output registered
  AST_CHAN_PIN: assert property (!soft_reset_i |=>
    receive_channel_clock_pin_o == $past(path_pin[0])
    && transmit_channel_clock_pin_o == $past(path_pin[1]))
    else $error("channel clock pin does not follow its path");

  // a write lands in the register, one cycle later on the pins
  sequence s_uout_write;
    (wr_uout && !soft_reset_i) ##1 !soft_reset_i;
  endsequence

  AST_RLT: assert property (s_uout_write |=>
    receive_level_threshold_o == $past(wdata_i[7:4], 2))
    else $error("threshold does not follow written bits");

endmodule

`default_nettype wire
